// File: rtl/fwls_pkg.sv
`default_nettype none
// Shared constants, types and helpers of the flash status register block.
package fwls_pkg;

  // Byte type used for register images on the pins.
  typedef logic [7:0] fwls_byte_t;

  // Opcodes decoded by this block.
  localparam fwls_byte_t OPC_ARM = 8'h06;
  localparam fwls_byte_t OPC_DISARM = 8'h04;
  localparam fwls_byte_t OPC_ID = 8'h9f;
  localparam fwls_byte_t OPC_STAT_RD = 8'h05;
  localparam fwls_byte_t OPC_STAT_WR = 8'h01;
  // Configuration read opcode; a plain default, overridable at the top.
  localparam fwls_byte_t OPC_CFG_RD_DEF = 8'h15;

  // Status byte field positions.
  localparam int BIT_LOCK = 7;
  localparam int BIT_QUAD = 6;
  localparam int BIT_PL_HI = 5;
  localparam int BIT_PL_LO = 2;
  localparam int BIT_LATCH = 1;
  localparam int BIT_BUSY = 0;
  // Configuration byte field positions.
  localparam int CFG_BIT_DC = 7;
  localparam int CFG_BIT_LOWEND = 3;

  // Reset values of the stored bits.
  localparam logic [3:0] RST_PL = 4'h0;
  localparam logic RST_BIT = 1'b0;

  // Identification bytes; the values are arbitrary.
  localparam fwls_byte_t ID_MAKER_DEF = 8'h5a;
  localparam fwls_byte_t ID_TYPE_DEF = 8'h3c;
  localparam fwls_byte_t ID_DEV_DEF = 8'h17;

  // Timing: system clock period and register-write interval, in ns.
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned TW_NS_DEF = 10000;

  // Bit counts of the readout units and the last bit of a byte.
  localparam logic [4:0] UNIT_ID_BITS = 5'h18;
  localparam logic [4:0] UNIT_REG_BITS = 5'h08;
  localparam logic [2:0] BYTE_LAST = 3'h7;

  // Readout unit selectors.
  localparam logic [1:0] SEL_STAT = 2'h0;
  localparam logic [1:0] SEL_CFG = 2'h1;
  localparam logic [1:0] SEL_ID = 2'h2;

  // Command frame states.
  typedef enum logic [2:0] {
    ST_OPC = 3'b000,
    ST_WAIT = 3'b001,
    ST_WDATA = 3'b010,
    ST_OUT = 3'b011,
    ST_SKIP = 3'b100
  } fwls_state_e;

  // Packs the status byte from its fields.
  function automatic fwls_byte_t fwls_pack_status(input logic lock, input logic quad,
      input logic [3:0] pl, input logic latch, input logic busy);
    fwls_byte_t b;
    b = 8'h00;
    b[BIT_LOCK] = lock;
    b[BIT_QUAD] = quad;
    b[BIT_PL_HI:BIT_PL_LO] = pl;
    b[BIT_LATCH] = latch;
    b[BIT_BUSY] = busy;
    return b;
  endfunction : fwls_pack_status

endpackage : fwls_pkg
`default_nettype wire

// File: rtl/fwls_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// Synchronised pin levels and serial clock events, from sampler to register logic.
interface fwls_link_if;
  logic cs_n;      // Chip select, synchronised level.
  logic cs_rise;   // Chip select rose, one-cycle pulse.
  logic sck_rise;  // Serial clock rose, one-cycle pulse.
  logic sck_fall;  // Serial clock fell, one-cycle pulse.
  logic sdi;       // Serial data lane zero, synchronised.
  logic guard_n;   // Lane two level, write guard when quad is off.
  logic pause_n;   // Lane three level, pause when quad is off.
  modport drv (output cs_n, cs_rise, sck_rise, sck_fall, sdi, guard_n, pause_n);
  modport use_side (input cs_n, cs_rise, sck_rise, sck_fall, sdi, guard_n, pause_n);
endinterface : fwls_link_if
`default_nettype wire

// File: rtl/fwls_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchronisers for the serial pins and edge detection of clock and select.
module fwls_pin_sync (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Raw pins.
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic io_lane_zero,
  input wire logic io_lane_two,
  input wire logic io_lane_three,
  // Synchronised view.
  fwls_link_if.drv link
);
  import fwls_pkg::*;

  logic [4:0] meta_ff;  // First stages, read only by the second stages.
  logic [4:0] sync_ff;  // Second stages: {lane3, lane2, sdi, sck, cs_n}.
  logic sck_d_ff;       // Delayed serial clock for edge detection.
  logic cs_d_ff;        // Delayed select for edge detection.

  // Idle select and data pins are high; reset loads that so no false select edge appears.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_ff <= 5'h1f;
      sync_ff <= 5'h1f;
    end else if (clk_en) begin
      meta_ff <= {io_lane_three, io_lane_two, io_lane_zero, serial_clock, chip_select_n};
      sync_ff <= meta_ff;
    end
  end

  // Third stage for edges, fed only from the second stage.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_d_ff <= 1'b1;
      cs_d_ff <= 1'b1;
    end else if (clk_en) begin
      sck_d_ff <= sync_ff[1];
      cs_d_ff <= sync_ff[0];
    end
  end

  // Events are gated by the enable so a frozen cycle does not repeat them.
  assign link.cs_n = sync_ff[0];
  assign link.cs_rise = clk_en & sync_ff[0] & ~cs_d_ff;
  assign link.sck_rise = clk_en & sync_ff[1] & ~sck_d_ff;
  assign link.sck_fall = clk_en & ~sync_ff[1] & sck_d_ff;
  assign link.sdi = sync_ff[2];
  assign link.guard_n = sync_ff[3];
  assign link.pause_n = sync_ff[4];

endmodule : fwls_pin_sync
`default_nettype wire

// File: rtl/fwls_regs.sv
`timescale 1ns/1ns
`default_nettype none
module fwls_regs #(
  parameter int unsigned TW_NS = fwls_pkg::TW_NS_DEF,
  parameter fwls_pkg::fwls_byte_t ID_MAKER = fwls_pkg::ID_MAKER_DEF,
  parameter fwls_pkg::fwls_byte_t ID_TYPE = fwls_pkg::ID_TYPE_DEF,
  parameter fwls_pkg::fwls_byte_t ID_DEV = fwls_pkg::ID_DEV_DEF,
  parameter fwls_pkg::fwls_byte_t CFG_READ_OPC = fwls_pkg::OPC_CFG_RD_DEF
) (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Serial pins from the host.
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic io_lane_zero,
  input wire logic io_lane_two,
  input wire logic io_lane_three,
  // Serial output lane and its enable.
  output logic serial_output,
  output logic serial_output_oe,
  // Requests from the program and erase engine.
  input wire logic mod_req,
  input wire logic mod_whole_wipe,
  input wire logic mod_protected,
  input wire logic op_busy,
  input wire logic op_done,
  // Grants and mode levels back to the device.
  output logic mod_go,
  output logic quad_cmds_allowed,
  output logic pause_active,
  output logic hw_lock_state,
  output logic protect_from_low_end,
  // Register images.
  output fwls_pkg::fwls_byte_t flash_status_byte,
  output fwls_pkg::fwls_byte_t config_byte
);
  import fwls_pkg::*;

  // Write interval in system clock cycles, rounded up.
  localparam int unsigned TW_CYC = (TW_NS + CLK_NS - 1) / CLK_NS;

  fwls_link_if lk ();  // Synchronised pin view.

  fwls_state_e st_ff;        // Frame state.
  logic [2:0] bit_cnt_ff;    // Bit position within the current byte.
  fwls_byte_t shin_ff;       // Shift-in register.
  fwls_byte_t opc_ff;        // Opcode of this frame.
  fwls_byte_t wstat_ff;      // First data byte of a register write.
  fwls_byte_t wcfg_ff;       // Second data byte of a register write.
  logic [1:0] wbytes_ff;     // Data bytes collected, saturating at two.
  logic [23:0] out_sh_ff;    // Output shift register, MSB leaves first.
  logic [4:0] out_left_ff;   // Bits left in the current unit.
  logic [1:0] out_sel_ff;    // Which unit is being read out.
  logic latch_ff;            // Write latch.
  logic lock_ff;             // Status lock bit.
  logic quad_ff;             // Quad pins enable.
  logic [3:0] pl_ff;         // Protect level bits.
  logic lowend_ff;           // Protect from low end, one-time.
  logic dc_ff;               // Dummy cycle selector in the config byte.
  logic tw_active_ff;        // Register write interval running.
  logic [23:0] tw_cnt_ff;    // Cycles left in the interval.
  logic so_ff;               // Output bit.
  logic so_oe_ff;            // Output drive enable.

  fwls_byte_t opc_now;       // Byte completed by the current rising edge.
  logic bit_edge;            // Rising edge taken.
  logic out_edge;            // Falling edge taken.
  logic busy_flag;           // Busy bit.
  logic arm_exec;            // Arm completes this cycle.
  logic disarm_exec;         // Disarm completes this cycle.
  logic wr_req;              // Well-framed register write ended.
  logic wr_start;            // Register write accepted.
  logic tw_end;              // Last cycle of the write interval.

  fwls_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .chip_select_n(chip_select_n),
    .serial_clock(serial_clock),
    .io_lane_zero(io_lane_zero),
    .io_lane_two(io_lane_two),
    .io_lane_three(io_lane_three),
    .link(lk.drv)
  );

  // Returns a readout unit, left-aligned, with its bit count.
  function automatic logic [28:0] unit_word(input logic [1:0] sel, input fwls_byte_t stat,
      input fwls_byte_t cfg);
    logic [28:0] w;
    w = {UNIT_REG_BITS, stat, 16'h0000};
    if (sel == SEL_CFG) begin
      w = {UNIT_REG_BITS, cfg, 16'h0000};
    end else if (sel == SEL_ID) begin
      w = {UNIT_ID_BITS, ID_MAKER, ID_TYPE, ID_DEV};
    end
    return w;
  endfunction : unit_word

  // pause only while quad is off.
  // quad on kills pause and lock state.
  assign pause_active = ~quad_ff & ~lk.pause_n;
  assign hw_lock_state = lock_ff & ~lk.guard_n & ~quad_ff;
  assign quad_cmds_allowed = quad_ff;
  assign protect_from_low_end = lowend_ff;

  // only lane zero is read as data; a paused bus takes no edges.
  // rising edges sample, falling edges shift out.
  assign opc_now = {shin_ff[6:0], lk.sdi};
  assign bit_edge = lk.sck_rise & ~lk.cs_n & ~pause_active;
  assign out_edge = lk.sck_fall & ~lk.cs_n & ~pause_active;

  // busy while an operation or the write interval runs.
  assign busy_flag = op_busy | tw_active_ff;

  // arm and disarm act on a lone-byte frame.
  // any extra clock moves the frame to skip.
  assign arm_exec = lk.cs_rise & (st_ff == ST_WAIT) & (opc_ff == OPC_ARM);
  assign disarm_exec = lk.cs_rise & (st_ff == ST_WAIT) & (opc_ff == OPC_DISARM);

  // select must rise on a byte boundary after at least one byte.
  assign wr_req = lk.cs_rise & (st_ff == ST_WDATA) & (bit_cnt_ff == 3'h0) & (wbytes_ff != 2'h0);
  assign wr_start = wr_req & latch_ff & ~hw_lock_state & ~busy_flag;
  assign tw_end = tw_active_ff & (tw_cnt_ff == 24'h000001);

  // whole wipe only with zero protect level.
  assign mod_go = mod_req & latch_ff & ~mod_protected & ~busy_flag
                  & ~(mod_whole_wipe & (pl_ff != RST_PL));

  assign flash_status_byte = fwls_pack_status(lock_ff, quad_ff, pl_ff, latch_ff, busy_flag);
  always_comb begin
    config_byte = 8'h00;
    config_byte[CFG_BIT_DC] = dc_ff;
    config_byte[CFG_BIT_LOWEND] = lowend_ff;
  end

  // Frame state: decides what the bytes after the opcode mean.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= ST_OPC;
    end else if (clk_en) begin
      if (lk.cs_n) begin
        st_ff <= ST_OPC;
      end else if (bit_edge) begin
        case (st_ff)
          ST_OPC: begin
            if (bit_cnt_ff == BYTE_LAST) begin
              case (opc_now)
                OPC_ARM, OPC_DISARM: st_ff <= ST_WAIT;
                OPC_STAT_WR: st_ff <= ST_WDATA;
                OPC_STAT_RD: st_ff <= ST_OUT;
                // no id read during an operation.
                OPC_ID: st_ff <= op_busy ? ST_SKIP : ST_OUT;
                CFG_READ_OPC: st_ff <= ST_OUT;
                default: st_ff <= ST_SKIP;
              endcase
            end
          end
          // Arm and disarm take no further clocks.
          ST_WAIT: st_ff <= ST_SKIP;
          default: st_ff <= st_ff;
        endcase
      end
    end
  end

  // Input shifting, bit count and captured bytes.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bit_cnt_ff <= 3'h0;
      shin_ff <= 8'h00;
      opc_ff <= 8'h00;
      wstat_ff <= 8'h00;
      wcfg_ff <= 8'h00;
      wbytes_ff <= 2'h0;
    end else if (clk_en) begin
      if (lk.cs_n) begin
        bit_cnt_ff <= 3'h0;
        wbytes_ff <= 2'h0;
      end else if (bit_edge) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        shin_ff <= opc_now;
        if (bit_cnt_ff == BYTE_LAST) begin
          if (st_ff == ST_OPC) begin
            opc_ff <= opc_now;
          end else if (st_ff == ST_WDATA) begin
            // First byte is status, second is configuration, later ones ignored.
            if (wbytes_ff == 2'h0) begin
              wstat_ff <= opc_now;
            end else if (wbytes_ff == 2'h1) begin
              wcfg_ff <= opc_now;
            end
            if (wbytes_ff != 2'h2) begin
              wbytes_ff <= wbytes_ff + 2'h1;
            end
          end
        end
      end
    end
  end

  // Write latch: set wins over any clear in the same cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latch_ff <= RST_BIT;
    end else if (clk_en) begin
      if (arm_exec) begin
        latch_ff <= 1'b1;
      end else if (disarm_exec | tw_end | op_done | (mod_req & mod_protected)) begin
        latch_ff <= 1'b0;
      end
    end
  end

  // Self-timed register write interval.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tw_active_ff <= 1'b0;
      tw_cnt_ff <= 24'h000000;
    end else if (clk_en) begin
      if (wr_start) begin
        tw_active_ff <= 1'b1;
        tw_cnt_ff <= 24'(TW_CYC);
      end else if (tw_active_ff) begin
        tw_cnt_ff <= tw_cnt_ff - 24'h000001;
        if (tw_end) begin
          tw_active_ff <= 1'b0;
        end
      end
    end
  end

  // Stored status and configuration bits, changed only by an accepted write.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_ff <= RST_BIT;
      quad_ff <= RST_BIT;
      pl_ff <= RST_PL;
      lowend_ff <= RST_BIT;
      dc_ff <= RST_BIT;
    end else if (clk_en) begin
      if (wr_start) begin
        // protect levels from the write only.
        lock_ff <= wstat_ff[BIT_LOCK];
        quad_ff <= wstat_ff[BIT_QUAD];
        pl_ff <= wstat_ff[BIT_PL_HI:BIT_PL_LO];
        if (wbytes_ff == 2'h2) begin
          // low-end bit can only be set.
          lowend_ff <= lowend_ff | wcfg_ff[CFG_BIT_LOWEND];
          dc_ff <= wcfg_ff[CFG_BIT_DC];
        end
      end
    end
  end

  // Output shifter: loads at the opcode, shifts and reloads on falling edges.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_sh_ff <= 24'h000000;
      out_left_ff <= 5'h00;
      out_sel_ff <= SEL_STAT;
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else if (clk_en) begin
      if (lk.cs_n | pause_active) begin
        // no drive with select high; pause also releases the lane.
        so_oe_ff <= 1'b0;
      end else if (bit_edge & (st_ff == ST_OPC) & (bit_cnt_ff == BYTE_LAST)) begin
        out_sel_ff <= (opc_now == OPC_ID) ? SEL_ID
                    : ((opc_now == CFG_READ_OPC) ? SEL_CFG : SEL_STAT);
        {out_left_ff, out_sh_ff} <= unit_word((opc_now == OPC_ID) ? SEL_ID
                    : ((opc_now == CFG_READ_OPC) ? SEL_CFG : SEL_STAT),
                    flash_status_byte, config_byte);
      end else if (out_edge & (st_ff == ST_OUT)) begin
        so_ff <= out_sh_ff[23];
        so_oe_ff <= 1'b1;
        if (out_left_ff == 5'h01) begin
          {out_left_ff, out_sh_ff} <= unit_word(out_sel_ff, flash_status_byte, config_byte);
        end else begin
          out_sh_ff <= {out_sh_ff[22:0], 1'b0};
          out_left_ff <= out_left_ff - 5'h01;
        end
      end
    end
  end

  assign serial_output = so_ff;
  assign serial_output_oe = so_oe_ff;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_arm;
    clk_en && arm_exec |=> latch_ff;
  endproperty
  a_arm: assert property (p_arm) else $error("arm did not set latch");

  property p_disarm;
    clk_en && disarm_exec |=> !latch_ff;
  endproperty
  a_disarm: assert property (p_disarm) else $error("disarm did not clear latch");

  property p_grant_latch;
    mod_go |-> latch_ff && !busy_flag;
  endproperty
  a_grant_latch: assert property (p_grant_latch) else $error("grant without latch");

  property p_protected;
    clk_en && mod_req && mod_protected && !arm_exec |-> !mod_go ##1 !latch_ff;
  endproperty
  a_protected: assert property (p_protected) else $error("protected target not refused");

  property p_wipe;
    mod_go && mod_whole_wipe |-> pl_ff == RST_PL;
  endproperty
  a_wipe: assert property (p_wipe) else $error("whole wipe with protect level set");

  property p_lock_refuse;
    hw_lock_state |-> !wr_start;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("write taken in lock state");

  property p_busy_interval;
    clk_en && wr_start |=> busy_flag && tw_active_ff;
  endproperty
  a_busy_interval: assert property (p_busy_interval) else $error("busy not set by write");

  property p_write_end;
    clk_en && tw_end && !arm_exec |=> !busy_flag || op_busy ##0 !latch_ff;
  endproperty
  a_write_end: assert property (p_write_end) else $error("write end left latch or busy");

  property p_select_high;
    lk.cs_n && clk_en |=> !serial_output_oe;
  endproperty
  a_select_high: assert property (p_select_high) else $error("output driven, select high");

  property p_quad;
    quad_ff |-> !hw_lock_state && !pause_active;
  endproperty
  a_quad: assert property (p_quad) else $error("quad on but lock or pause active");

  property p_misaligned;
    lk.cs_rise && (st_ff == ST_WDATA) && (bit_cnt_ff != 3'h0) |-> !wr_start;
  endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned write taken");

  c_arm: cover property (arm_exec);
  c_write: cover property (wr_start ##1 tw_active_ff[*4]);
  c_id: cover property (out_edge && out_sel_ff == SEL_ID && out_left_ff == 5'h01);
  c_stat: cover property (out_edge && out_sel_ff == SEL_STAT && out_left_ff == 5'h01);

endmodule : fwls_regs
`default_nettype wire

// File: test/fwls_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Serial host: frames one command, clock idles low and stops between frames.
module fwls_host_model (
  // Serial pins towards the device.
  output logic chip_select_n,
  output logic serial_clock,
  output logic io_lane_zero,
  // Serial data back from the device.
  input wire logic serial_output
);
  // Deselected, clock stopped, data line idle.
  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    io_lane_zero = 1'b1;
  end
  // Sends ntx bits MSB first, then clocks nrx bits in; select rises after a fall.
  // whole frames
  task automatic frame(input logic [31:0] tx, input int ntx, input int nrx,
      output logic [31:0] rx);
    rx = 32'h0;
    chip_select_n = 1'b0;
    #200;
    for (int i = ntx - 1; i >= 0; i--) begin
      io_lane_zero = tx[i];
      #200 serial_clock = 1'b1;
      #200 serial_clock = 1'b0;
    end
    for (int i = 0; i < nrx; i++) begin
      #200 serial_clock = 1'b1;
      #150 rx = {rx[30:0], serial_output};
      #50 serial_clock = 1'b0;
    end
    #200 chip_select_n = 1'b1;
    // A released line shows the inverse of its last level.
    io_lane_zero = ~io_lane_zero;
    #400;
  endtask : frame
endmodule : fwls_host_model
`default_nettype wire

// File: test/fwls_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
// Bench: a field model of the status byte is compared with the design at every status read.
module fwls_regs_test;
  import fwls_pkg::*;
  localparam int TW_CYC = 500 / CLK_NS;  // Write interval in clocks.
  logic clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, io_lane_two = 1'b1, io_lane_three = 1'b1;
  logic chip_select_n, serial_clock, io_lane_zero, serial_output, serial_output_oe, mod_go;
  logic quad_cmds_allowed, pause_active, hw_lock_state, protect_from_low_end, seen_oe;
  logic mod_req = 1'b0, mod_whole_wipe = 1'b0, mod_protected = 1'b0;
  logic op_busy = 1'b0, op_done = 1'b0;
  fwls_byte_t flash_status_byte, config_byte, s, c;
  int n_errors = 0, num_checks = 0, busy_cyc = 0;
  int m_lock = 0, m_quad = 0, m_pl = 0, m_latch = 0, m_busy = 0;  // Model fields.
  logic [31:0] rx;
  always #25 clk_sys = ~clk_sys;
  fwls_regs #(.TW_NS(500)) i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock), .io_lane_zero(io_lane_zero),
    .io_lane_two(io_lane_two), .io_lane_three(io_lane_three), .serial_output(serial_output),
    .serial_output_oe(serial_output_oe), .mod_req(mod_req), .mod_whole_wipe(mod_whole_wipe),
    .mod_protected(mod_protected), .op_busy(op_busy), .op_done(op_done), .mod_go(mod_go),
    .quad_cmds_allowed(quad_cmds_allowed), .pause_active(pause_active),
    .hw_lock_state(hw_lock_state), .protect_from_low_end(protect_from_low_end),
    .flash_status_byte(flash_status_byte), .config_byte(config_byte));
  fwls_host_model i_host (.chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .io_lane_zero(io_lane_zero), .serial_output(serial_output));
  // Counts busy clocks and notes any drive of the output lane, away from the launching edge.
  always @(negedge clk_sys) begin
    if (flash_status_byte[0] === 1'b1) busy_cyc++;
    if (serial_output_oe === 1'b1) seen_oe = 1'b1;
  end
  function automatic fwls_byte_t exp_st();
    return {m_lock[0], m_quad[0], m_pl[3:0], m_latch[0], m_busy[0]};
  endfunction : exp_st
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic cmd(input fwls_byte_t op);
    i_host.frame({24'h0, op}, 8, 0, rx);
    if (op == OPC_ARM) m_latch = 1;
    if (op == OPC_DISARM) m_latch = 0;
  endtask : cmd
  // Two status bytes in one frame, both against the model.
  task automatic rd_stat(input string t);
    i_host.frame({24'h0, OPC_STAT_RD}, 8, 16, rx);
    check("status pins", flash_status_byte, exp_st());
    check("status read", rx[15:0], {2{exp_st()}});
    $display("test %s done", t);
  endtask : rd_stat
  // One engine request; the grant is combinational.
  task automatic eng(input logic wipe, input logic prot, input logic go);
    @(negedge clk_sys) {mod_req, mod_whole_wipe, mod_protected} = {1'b1, wipe, prot};
    #1 check("grant", mod_go, go);
    @(negedge clk_sys) mod_req = 1'b0;
    if (prot) m_latch = 0;
  endtask : eng
  // Arm, then a register write of n bits; waits out the interval under a bound.
  task automatic wr(input fwls_byte_t st, input fwls_byte_t cf, input int n, input int cyc);
    cmd(OPC_ARM);
    busy_cyc = 0;
    i_host.frame({8'h0, OPC_STAT_WR, st, cf} >> (24 - n), n, 0, rx);
    for (int i = 0; i < 200 && flash_status_byte[0] !== 1'b0; i++) @(negedge clk_sys);
    if (flash_status_byte[0] !== 1'b0) begin
      n_errors++;
      stop_test();
    end
    check("busy clocks", busy_cyc, cyc);
    if (cyc > 0) m_latch = 0;
  endtask : wr
  initial begin
    #2000000 n_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h098782d3));
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    rd_stat("reset");
    @(negedge clk_sys) io_lane_two = 1'($urandom);
    cmd(OPC_ARM);
    @(negedge clk_sys) io_lane_two = 1'b1;
    rd_stat("arm");
    cmd(OPC_DISARM);
    rd_stat("disarm");
    i_host.frame({23'h0, OPC_ARM, 1'b0}, 9, 0, rx);
    rd_stat("long arm");
    eng(1'b0, 1'b0, 1'b0);
    cmd(OPC_ARM);
    eng(1'b0, 1'b1, 1'b0);
    rd_stat("protected");
    cmd(OPC_ARM);
    eng(1'b1, 1'b0, 1'b1);
    @(negedge clk_sys) op_busy = 1'b1;
    m_busy = 1;
    rd_stat("busy");
    seen_oe = 1'b0;
    i_host.frame({24'h0, OPC_ID}, 8, 8, rx);
    check("id while busy", seen_oe, 1'b0);
    @(negedge clk_sys) {op_busy, op_done} = 2'b01;
    @(negedge clk_sys) op_done = 1'b0;
    {m_busy, m_latch} = 0;
    rd_stat("done");
    s = {2'b10, 4'($urandom) | 4'h1, 2'b00};
    c = {1'($urandom), 7'h08};
    wr(s, c, 20, 0);
    m_latch = 1;
    rd_stat("misaligned");
    wr(s, c, 24, TW_CYC);
    m_lock = 1;
    m_pl = int'(s[5:2]);
    rd_stat("write");
    check("config", config_byte, c);
    i_host.frame({24'h0, OPC_CFG_RD_DEF}, 8, 8, rx);
    check("config read", rx[7:0], c);
    cmd(OPC_ARM);
    eng(1'b1, 1'b0, 1'b0);
    @(negedge clk_sys) clk_en = 1'b0;
    @(negedge clk_sys) {io_lane_two, io_lane_three} = 2'b00;
    repeat (6) @(negedge clk_sys);
    check("frozen lanes", {hw_lock_state, pause_active}, 2'b00);
    @(negedge clk_sys) clk_en = 1'b1;
    repeat (6) @(negedge clk_sys);
    check("lock state", hw_lock_state, 1'b1);
    check("pause", pause_active, 1'b1);
    @(negedge clk_sys) io_lane_three = 1'b1;
    wr(8'h40, 8'h00, 24, 0);
    m_latch = 1;
    rd_stat("locked");
    @(negedge clk_sys) io_lane_two = 1'b1;
    wr(8'hc0, 8'h00, 24, TW_CYC);
    m_lock = 1;
    m_quad = 1;
    m_pl = 0;
    rd_stat("quad");
    check("low end kept", config_byte, 8'h08);
    check("low end pin", protect_from_low_end, 1'b1);
    @(negedge clk_sys) {io_lane_two, io_lane_three} = 2'b00;
    repeat (6) @(negedge clk_sys);
    check("quad lanes", {quad_cmds_allowed, hw_lock_state, pause_active}, 3'b100);
    @(negedge clk_sys) {io_lane_two, io_lane_three} = 2'b11;
    i_host.frame({24'h0, OPC_ID}, 8, 24, rx);
    check("id", rx[23:0], {ID_MAKER_DEF, ID_TYPE_DEF, ID_DEV_DEF});
    i_host.frame({24'h0, OPC_ID}, 8, 12, rx);
    check("id cut", {rx[11:0], serial_output_oe}, {ID_MAKER_DEF, ID_TYPE_DEF[7:4], 1'b0});
    $display("test id done");
    stop_test();
  end
endmodule : fwls_regs_test
`default_nettype wire
